// [fault_pin_mask.sv]
// Fault pin masking, mask register and dummy write target.
// Assumes the SPI decoder hands over one-cycle register strobes on i_clk.
module fault_pin_mask_and_dummy_reg_rdmux
  import fault_pin_pkg::*;
(
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_mask,
  output logic      [7:0] o_data,
  output logic            o_hit
);
  // ==========================================================
  // Read decode
  always_comb begin
    o_data = 8'h00;
    o_hit  = 1'b0;
    if (i_addr == ADDR_FAULT_PIN_SOURCE_MASK) begin
      o_data = i_mask;
      o_hit  = 1'b1;
    end
  end
endmodule // fault_pin_mask_and_dummy_reg_rdmux

// What this block does
// - Checksum error drives the fault pin only while mask bit 7 is one.
// - Power-on flag drives the fault pin only while mask bit 6 is one.
// - Secondary fault summary drives the pin only while mask bit 5 is one.
// - Field-supply-low flag drives the pin only while mask bit 2 is one.
// - Field-supply-missing flag drives the pin only while mask bit 1 is one.
// - Mask bits 4:3 and 0 take any value and do not affect the pin.
// - The mask register resets to 0xC0.
// - A write to 0x26 stores nothing yet input-state bits still shift out.
// - Without field supply both supply flags stay set.
// - Without field supply the pin stays low while a supply mask bit is set.
// - Non-sticky pin is the inverted OR of unmasked real-time sources.
// - Sticky pin stays low after an unmasked latched bit until fault read.
module fault_pin_mask_and_dummy_reg
  import fault_pin_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Register requests from SPI decoder
  input  reg_req_s        i_req,
  input  wire logic       i_primary_fault_rd,
  // Fault sources
  input  fault_src_s      i_src_rt,
  input  fault_src_s      i_src_latched,
  input  wire logic       i_sticky_pin_select,
  // Pins
  input  wire logic       i_field_supply_pin,
  input  wire logic [7:0] i_input_state_bits,
  // Outputs
  output logic            o_fault_n,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid,
  output logic [7:0]      o_shift_out,
  output logic            o_shift_load,
  output logic [7:0]      o_mask
);
  typedef struct packed {
    logic [7:0] mask;
    logic       sticky_hold;
    logic       fault_n;
    logic [7:0] rdata;
    logic       rvalid;
    logic [7:0] shift_out;
    logic       shift_load;
  } st_s;

  st_s        st_q, st_d;
  logic       supply_ok;
  logic [7:0] rd_data;
  logic       rd_hit;
  fault_src_s rt_eff;
  fault_src_s lat_eff;
  logic       rt_any;
  logic       lat_any;

  // ==========================================================
  // Field supply presence
  fault_sync3 #(
    .WIDTH (1)
  ) u_supply_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_field_supply_pin),
    .o_sync  (supply_ok)
  );

  fault_pin_mask_and_dummy_reg_rdmux u_rdmux (
    .i_addr (i_req.addr),
    .i_mask (st_q.mask),
    .o_data (rd_data),
    .o_hit  (rd_hit)
  );

  // ==========================================================
  // Fault sources
  always_comb begin
    rt_eff  = i_src_rt;
    lat_eff = i_src_latched;
    // Absent field supply forces both supply flags set
    if (!supply_ok) begin
      rt_eff.field_supply_low_flag      = 1'b1;
      rt_eff.field_supply_missing_flag  = 1'b1;
      lat_eff.field_supply_low_flag     = 1'b1;
      lat_eff.field_supply_missing_flag = 1'b1;
    end
    // Bits 4:3 and 0 are never looked at
    rt_any  = masked_any(rt_eff, st_q.mask);
    lat_any = masked_any(lat_eff, st_q.mask);
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_d            = st_q;
    st_d.rvalid     = 1'b0;
    st_d.shift_load = 1'b0;
    if (i_req.wr_stb) begin
      if (i_req.addr == ADDR_FAULT_PIN_SOURCE_MASK) begin
        st_d.mask = i_req.wdata;
      end else if (i_req.addr == ADDR_DUMMY_WRITE_TARGET) begin
        st_d.mask = st_q.mask; // Nothing stored
      end
      // Input states shift out on every write frame
      st_d.shift_out  = i_input_state_bits;
      st_d.shift_load = 1'b1;
    end
    if (i_req.rd_stb) begin
      st_d.rdata     = rd_hit ? rd_data : 8'h00;
      st_d.rvalid    = 1'b1;
      st_d.shift_out = i_input_state_bits;
      st_d.shift_load = 1'b1;
    end
    // Sticky hold: new fault wins over clear by read
    if (lat_any) begin
      st_d.sticky_hold = 1'b1;
    end else if (i_primary_fault_rd) begin
      st_d.sticky_hold = 1'b0;
    end
    if (i_sticky_pin_select) begin
      st_d.fault_n = ~(st_q.sticky_hold | lat_any);
    end else begin
      st_d.fault_n = ~rt_any;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q            <= '0;
      st_q.mask       <= RST_FAULT_PIN_SOURCE_MASK;
      st_q.fault_n    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_fault_n    = st_q.fault_n;
  assign o_rdata      = st_q.rdata;
  assign o_rvalid     = st_q.rvalid;
  assign o_shift_out  = st_q.shift_out;
  assign o_shift_load = st_q.shift_load;
  assign o_mask       = st_q.mask;
endmodule // fault_pin_mask_and_dummy_reg

// [fault_pin_pkg.sv]
// Package for the fault pin masking block: register map, field layout, carriers.
// Assumes a single 25 MHz clock domain and an SPI frame decoder outside.
package fault_pin_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_FAULT_PIN_SOURCE_MASK = 8'h24;
  localparam logic [7:0] ADDR_DUMMY_WRITE_TARGET    = 8'h26;
  localparam logic [7:0] RST_FAULT_PIN_SOURCE_MASK  = 8'hC0;

  // ==========================================================
  // Mask bit positions
  localparam int unsigned BIT_CHECKSUM_ERROR_PIN_ENABLE    = 7;
  localparam int unsigned BIT_POWER_ON_PIN_ENABLE          = 6;
  localparam int unsigned BIT_SECONDARY_SUMMARY_PIN_ENABLE = 5;
  localparam int unsigned BIT_SUPPLY_LOW_PIN_ENABLE        = 2;
  localparam int unsigned BIT_SUPPLY_MISSING_PIN_ENABLE    = 1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic checksum_error;
    logic power_on;
    logic secondary_fault_summary;
    logic field_supply_low_flag;
    logic field_supply_missing_flag;
  } fault_src_s;

  typedef struct packed {
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Reduce five fault sources through the mask to one request
  function automatic logic masked_any(input fault_src_s src, input logic [7:0] mask);
    masked_any = (src.checksum_error            & mask[BIT_CHECKSUM_ERROR_PIN_ENABLE])
               | (src.power_on                  & mask[BIT_POWER_ON_PIN_ENABLE])
               | (src.secondary_fault_summary   & mask[BIT_SECONDARY_SUMMARY_PIN_ENABLE])
               | (src.field_supply_low_flag     & mask[BIT_SUPPLY_LOW_PIN_ENABLE])
               | (src.field_supply_missing_flag & mask[BIT_SUPPLY_MISSING_PIN_ENABLE]);
  endfunction

endpackage

// [fault_sync3.sv]
// Three flop synchroniser with agreement filter for pin level inputs.
// Assumes the input is asynchronous to i_clk.
module fault_sync3
  import fault_pin_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Data
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } st_s;

  st_s st_q, st_d;

  // ==========================================================
  // Next state
  always_comb begin
    st_d    = st_q;
    st_d.s1 = i_async;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Only s2 and s3 are compared; s1 may be metastable
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.out[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.out;
endmodule // fault_sync3

// [fault_pin_mask_and_dummy_reg_monitor.sv]
// Checker of the fault pin block, watching its ports only.
// Assumes it is bound into the block from the bench top.
module fault_pin_mask_and_dummy_reg_monitor
  import fault_pin_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  // Inputs
  input reg_req_s        i_req,
  input fault_src_s      i_src_rt,
  input wire logic       i_sticky_pin_select,
  input wire logic       i_field_supply_pin,
  input wire logic [7:0] i_input_state_bits,
  // Outputs
  input wire logic       o_fault_n,
  input wire logic [7:0] o_shift_out,
  input wire logic       o_shift_load,
  input wire logic [7:0] o_mask
);
  // ====
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic       q = !i_sticky_pin_select;
  wire logic [4:0] s = i_src_rt;
  wire logic       w = i_req.wr_stb;
  a_crc_pin: assert property (q && s[4] && o_mask[7] |=> !o_fault_n) else $error("crc");
  a_por_pin: assert property (q && s[3] && o_mask[6] |=> !o_fault_n) else $error("por");
  a_sec_pin: assert property (q && s[2] && o_mask[5] |=> !o_fault_n) else $error("sec");
  // Supply bits masked, so the pin must not depend on the synchroniser
  a_quiet_pin: assert property (q && s == 5'h00 && o_mask[2:1] == 2'b00
    |=> o_fault_n) else $error("quiet");
  a_low_pin: assert property (q && s[1] && o_mask[2] |=> !o_fault_n) else $error("low");
  a_miss_pin: assert property (q && s[0] && o_mask[1] |=> !o_fault_n) else $error("miss");
  // Six cycles covers the supply synchroniser delay
  a_no_supply: assert property (!i_field_supply_pin [*6]
    ##0 (q && o_mask[2:1] != 2'b00) |=> !o_fault_n) else $error("supply");
  a_mask_write: assert property (w && i_req.addr == ADDR_FAULT_PIN_SOURCE_MASK
    |=> o_mask == $past(i_req.wdata)) else $error("mask");
  a_dummy_keep: assert property (w && i_req.addr != ADDR_FAULT_PIN_SOURCE_MASK
    |=> $stable(o_mask)) else $error("dummy");
  a_shift_out: assert property (w || i_req.rd_stb |=> o_shift_load
    && o_shift_out == $past(i_input_state_bits)) else $error("shift");
  cover property (w && i_req.addr == ADDR_DUMMY_WRITE_TARGET);
  cover property (!i_field_supply_pin && !o_fault_n);
  cover property (i_sticky_pin_select && !o_fault_n);
endmodule // fault_pin_mask_and_dummy_reg_monitor

// [fault_host_model.sv]
// Host model issuing one-cycle register strobes.
// Assumes it shares i_clk with the block.
module fault_host_model
  import fault_pin_pkg::*;
(
  input  wire logic i_clk,
  output reg_req_s  o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // One strobe at a time; idle address and data are scrambled, not held
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{wr_stb: wr, rd_stb: !wr, addr: a, wdata: d};
    @(posedge i_clk);
    o_req <= '{wr_stb: 1'b0, rd_stb: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule // fault_host_model

// [fault_pin_mask_and_dummy_reg_tb_top.sv]
// Bench top: host model, scoreboard of reads, pin and shift checks.
// Assumes package, block, monitor and host model compiled first.
`define CHK(nm, x, g) begin n_checks++; if ((g) !== (x)) begin mismatches++; \
  $display("[FAIL] %s exp=%h got=%h", nm, x, g); end end
module fault_pin_mask_and_dummy_reg_tb_top
  import fault_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk = 0, i_rst_n = 0, i_primary_fault_rd = 0;
  logic       i_sticky_pin_select = 0, i_field_supply_pin = 0;
  logic [7:0] i_input_state_bits = 8'h00, o_rdata, o_shift_out, o_mask, mk, e, rx;
  fault_src_s i_src_rt = '0, i_src_latched = '0;
  reg_req_s   i_req;
  logic       o_fault_n, o_rvalid, o_shift_load;
  int         mismatches = 0, n_checks = 0;
  logic [7:0] expq[$];
  int         bits[5] = '{7, 6, 5, 2, 1};
  always #20 i_clk = ~i_clk;
  fault_host_model host (.i_clk, .o_req(i_req));
  fault_pin_mask_and_dummy_reg DUT (.i_clk, .i_rst_n, .i_req, .i_primary_fault_rd,
    .i_src_rt, .i_src_latched, .i_sticky_pin_select, .i_field_supply_pin,
    .i_input_state_bits, .o_fault_n, .o_rdata, .o_rvalid, .o_shift_out,
    .o_shift_load, .o_mask);
  // ====
  // Tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    e = 8'($urandom);
    i_input_state_bits <= e;
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    expq.push_back(x);
    host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic pin(input logic x);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("fault pin", x, o_fault_n)
    // Hand back on a rising edge so that callers drive inputs there
    @(posedge i_clk);
  endtask
  // ====
  // Scoreboard of read answers
  always @(negedge i_clk) begin
    if (o_rvalid === 1'b1) begin
      rx = (expq.size() > 0) ? expq.pop_front() : 8'hxx;
      `CHK("read data", rx, o_rdata)
    end
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    print_verdict();
  end
  // ====
  // Main sequence
  initial begin
    void'($urandom(32'h7d3a_3b41));
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    `CHK("mask reset", RST_FAULT_PIN_SOURCE_MASK, o_mask)
    pin(1'b1);
    wr(ADDR_FAULT_PIN_SOURCE_MASK, 8'h06);
    pin(1'b0);
    wr(ADDR_FAULT_PIN_SOURCE_MASK, 8'h00);
    pin(1'b1);
    i_field_supply_pin <= 1'b1;
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < 10; i++) begin
      mk = 8'(($urandom & 32'h19) | ((i % 2) << bits[i / 2]));
      wr(ADDR_FAULT_PIN_SOURCE_MASK, mk);
      rd(ADDR_FAULT_PIN_SOURCE_MASK, mk);
      i_src_rt <= fault_src_s'(5'h10 >> (i / 2));
      pin((i % 2) == 0);
      i_src_rt <= '0;
    end
    wr(ADDR_DUMMY_WRITE_TARGET, ~mk);
    @(negedge i_clk);
    `CHK("shift out", e, o_shift_out)
    rd(ADDR_FAULT_PIN_SOURCE_MASK, mk);
    rd(8'h30, 8'h00);
    i_sticky_pin_select <= 1'b1;
    wr(ADDR_FAULT_PIN_SOURCE_MASK, 8'h80);
    i_src_latched.checksum_error <= 1'b1;
    @(posedge i_clk);
    i_src_latched <= '0;
    pin(1'b0);
    i_primary_fault_rd <= 1'b1;
    @(posedge i_clk);
    i_primary_fault_rd <= 1'b0;
    pin(1'b1);
    for (int k = 0; k < 20 && expq.size() > 0; k++) @(posedge i_clk);
    if (expq.size() != 0) mismatches++;
    print_verdict();
  end
endmodule // fault_pin_mask_and_dummy_reg_tb_top
bind fault_pin_mask_and_dummy_reg fault_pin_mask_and_dummy_reg_monitor mon (.i_clk,
  .i_rst_n, .i_req, .i_src_rt, .i_sticky_pin_select, .i_field_supply_pin,
  .i_input_state_bits, .o_fault_n, .o_shift_out, .o_shift_load, .o_mask);
